// file: src/mds_defs.svh
// address map, bit positions and timing counts of the memory subsystem
`ifndef MDS_DEFS_SVH
`define MDS_DEFS_SVH
`define MDS_REGF_END     16'h0020
`define MDS_IO_END       16'h0060
`define MDS_EXT_END      16'h0100
`define MDS_SRAM_END     16'h0900
`define MDS_IO_BASE      16'h0020
`define MDS_SHORT_IO_OFS 16'h0020
`define MDS_EECR_ADR     16'h003F
`define MDS_EEDR_ADR     16'h0040
`define MDS_EEARL_ADR    16'h0041
`define MDS_EEARH_ADR    16'h0042
`define MDS_EECR_READ    0
`define MDS_EECR_STROBE  1
`define MDS_EECR_ARM     2
`define MDS_EECR_RDYIE   3
`define MDS_EE_RD_STALL  3'h4
`define MDS_EE_WR_STALL  3'h2
`define MDS_ARM_WINDOW   3'h4
`define MDS_EE_WRITE_RC  27072
`define MDS_BOOT_START   14'h3C00
`define MDS_FLASH_WORDS  16384
`define MDS_EE_BYTES     1024
`define MDS_SRAM_BYTES   2048
`define MDS_IO_BYTES     224
`endif

// file: src/mds_eeprom.sv
// data eeprom array with self-timed byte write
`timescale 1ns/100ps
`default_nettype none
`include "mds_defs.svh"
module mds_eeprom #(
  parameter int unsigned RC_CYCLES = `MDS_EE_WRITE_RC
)(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       rc_tick,
  input  wire logic       wr_go,
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wr_data,
  output logic            busy,
  output logic [7:0]      rd_byte
);
  logic [7:0]  mem [0:`MDS_EE_BYTES-1];
  logic [14:0] cnt;
  logic [9:0]  wa;
  logic [7:0]  wd;
  logic        done;

  ////////////////////////////////////////////////////////////
  // byte-wide read, data valid at once
  assign rd_byte = mem[addr];
  assign done    = busy && rc_tick && (cnt == 15'(RC_CYCLES - 1));

  // write timer counts rc ticks; reset cannot abort a running write
  always_ff @(posedge ref_clk)
  begin
    if (busy)
    begin
      if (done)
        busy <= 1'b0;
      if (rc_tick)
        cnt <= cnt + 15'h0001;
    end
    else if (!rst_b)
    begin
      busy <= 1'b0;
      cnt  <= 15'h0000;
    end
    else if (wr_go)
    begin
      busy <= 1'b1;
      cnt  <= 15'h0000;
      wa   <= addr;
      wd   <= wr_data;
    end
  end

  // the cell is committed at the end of the timed window
  always_ff @(posedge ref_clk)
  begin
    if (done)
      mem[wa] <= wd;
  end
endmodule
`default_nettype wire

// file: src/mds_flash.sv
// program flash of 16-bit words split into application and boot sections
`timescale 1ns/100ps
`default_nettype none
`include "mds_defs.svh"
module mds_flash (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [13:0] pc,
  output logic [15:0]      instr,
  output logic             in_boot,
  input  wire logic        spm_req,
  input  wire logic [13:0] spm_addr,
  input  wire logic [15:0] spm_data,
  input  wire logic        boot_lock,
  input  wire logic        app_lock,
  output logic             spm_refused
);
  logic [15:0] mem [0:`MDS_FLASH_WORDS-1];
  logic        spm_locked;

  // section test shared by fetch and self-programming
  function automatic logic is_boot(input logic [13:0] a);
    return a >= `MDS_BOOT_START;
  endfunction

  ////////////////////////////////////////////////////////////
  // each section has its own lock
  assign spm_locked = is_boot(spm_addr) ? boot_lock : app_lock;

  always_ff @(posedge ref_clk)
  begin
    if (spm_req && !spm_locked)
      mem[spm_addr] <= spm_data;
  end

  // 14-bit pc reaches all 16K words
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      instr       <= 16'h0000;
      in_boot     <= 1'b0;
      spm_refused <= 1'b0;
    end
    else
    begin
      instr       <= mem[pc];
      in_boot     <= is_boot(pc);
      spm_refused <= spm_req && spm_locked;
    end
  end
endmodule
`default_nettype wire

// file: src/mds_memsys.sv
// data space decode, addressing modes, sram and eeprom access path
//
// What this block does
// - lowest 32 addresses registers, next 64 io, next 160 extended io, next 2048 sram, rest faults.
// - extended io 0x60-0xFF reachable only by data-space loads and stores.
// - displacement mode adds 0..63 to the Y or Z pointer.
// - pre-decrement and post-increment update the pointer and write it back.
// - direct addressing reaches everything; all regions work in all five modes.
// - every sram access completes in two clock cycles.
// - program flash is 16K words of 16 bits, addressed by a 14-bit pc.
// - flash split into boot and application sections, each separately locked.
// - data eeprom is a 1K byte space, accessed a byte at a time.
// - eeprom address, data and control registers sit in io space.
// - an eeprom read stalls the cpu four cycles.
// - starting an eeprom write stalls the cpu two cycles.
// - writes are self-timed; a pollable status shows when the next may start.
// - a write starts only after the arming step; software must arm first.
// - power-down during a write lets it finish; the timing clock keeps running.
// - reset during an eeprom write does not abort it.
// - arm bit clears four cycles after set; strobe must come inside that window.
// - the strobe bit clears when the self-timed write finishes.
// - a write takes 27,072 calibrated oscillator cycles.
// - while writing, eeprom reads are blocked and the address is frozen.
`timescale 1ns/100ps
`default_nettype none
`include "mds_defs.svh"
module mds_memsys
  import mds_pkg::*;
#(
  parameter int unsigned EE_WRITE_RC_CYCLES = `MDS_EE_WRITE_RC
)(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic        acc_short_io,
  input  wire logic [2:0]  acc_mode,
  input  wire logic [1:0]  acc_ptr,
  input  wire logic [15:0] acc_addr,
  input  wire logic [5:0]  acc_disp,
  input  wire logic [7:0]  acc_wdata,
  output logic             acc_ack,
  output logic [7:0]       acc_rdata,
  output logic             acc_fault,
  output logic             cpu_stall,
  input  wire logic [13:0] fetch_pc,
  output logic [15:0]      fetch_instr,
  output logic             fetch_in_boot,
  input  wire logic        spm_req,
  input  wire logic [13:0] spm_addr,
  input  wire logic [15:0] spm_data,
  input  wire logic        boot_lock,
  input  wire logic        app_lock,
  output logic             spm_refused,
  input  wire logic        rc_tick,
  input  wire logic        powerdown_req,
  output logic             rc_osc_hold,
  output logic             powerdown_full
);
  logic [7:0]  rf     [0:31];
  logic [7:0]  io_mem [0:`MDS_IO_BYTES-1];
  logic [7:0]  sram   [0:`MDS_SRAM_BYTES-1];
  mds_state_t  st;
  mds_mode_t   mode;
  mds_ptr_t    psel;
  mds_ptr_t    lat_psel;
  mds_region_t rgn;
  logic [15:0] lat_addr;
  logic        lat_we;
  logic [7:0]  lat_wd;
  logic        lat_wb;
  logic [15:0] lat_pnew;
  logic [9:0]  ee_addr;
  logic [7:0]  ee_data;
  logic        ee_arm;
  logic        ee_rdyie;
  logic [2:0]  arm_cnt;
  logic [2:0]  stall_cnt;
  logic        ee_busy;
  logic [7:0]  ee_rd_byte;
  logic [15:0] ptr_val;
  logic [15:0] lat_ptr_val;
  logic [15:0] disp_ext;
  logic [15:0] ea;
  logic [15:0] next_ptr;
  logic        ptr_wb;
  logic        take;
  logic        in_acc;
  logic [15:0] io_ofs;
  logic [15:0] sram_ofs;
  logic        hit_eecr;
  logic        hit_eedr;
  logic        hit_earl;
  logic        hit_earh;
  logic [7:0]  rd_mux;
  logic        ee_cr_wr;
  logic        ee_arm_set;
  logic        ee_arm_clr;
  logic        ee_wr_go;
  logic        ee_rd_go;
  logic        ee_ar_wr;
  logic [2:0]  next_stall_cnt;
  logic [2:0]  next_arm_cnt;
  logic        next_arm;

  // pointer pair read from r26/r28/r30 and the register above
  function automatic logic [15:0] ptr_of(input mds_ptr_t p);
    logic [4:0] lo;
    lo = 5'd26 + {2'b00, p, 1'b0};
    return {rf[lo + 5'd1], rf[lo]};
  endfunction

  ////////////////////////////////////////////////////////////
  // effective address of the incoming request
  assign mode     = mds_mode_t'(acc_mode);
  assign psel     = mds_ptr_t'(acc_ptr);
  assign ptr_val  = ptr_of(psel);
  assign disp_ext = (psel == MDS_PX) ? 16'h0000 : {10'h000, acc_disp};
  // short io opcodes carry 6 bits, so extended io is out of their reach
  assign ea = acc_short_io ? ({10'h000, acc_addr[5:0]} + `MDS_SHORT_IO_OFS) :
              (mode == MDS_DIRECT) ? acc_addr :
              (mode == MDS_DISP) ? ptr_val + disp_ext :
              (mode == MDS_PREDEC) ? ptr_val - 16'h0001 : ptr_val;
  assign next_ptr = (mode == MDS_PREDEC) ? ptr_val - 16'h0001 : ptr_val + 16'h0001;
  assign ptr_wb   = !acc_short_io && ((mode == MDS_PREDEC) || (mode == MDS_POSTINC));
  // no new access while the cpu is held for the eeprom
  assign take     = acc_req && (st == MDS_IDLE) && (stall_cnt == 3'h0);

  // request latch; second cycle does the access
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st       <= MDS_IDLE;
      lat_addr <= 16'h0000;
      lat_we   <= 1'b0;
      lat_wd   <= 8'h00;
      lat_psel <= MDS_PX;
      lat_wb   <= 1'b0;
      lat_pnew <= 16'h0000;
    end
    else
    begin
      case (st)
        MDS_IDLE:
        begin
          if (take)
          begin
            st       <= MDS_ACCESS;
            lat_addr <= ea;
            lat_we   <= acc_write;
            lat_wd   <= acc_wdata;
            lat_psel <= psel;
            lat_wb   <= ptr_wb;
            lat_pnew <= next_ptr;
          end
        end
        MDS_ACCESS:
          st <= MDS_IDLE;
        default:
          st <= MDS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // region and eeprom register decode of the latched address
  assign in_acc   = (st == MDS_ACCESS);
  assign rgn      = mds_region(lat_addr);
  assign io_ofs   = lat_addr - `MDS_IO_BASE;
  assign sram_ofs = lat_addr - `MDS_EXT_END;
  assign hit_eecr = (lat_addr == `MDS_EECR_ADR);
  assign hit_eedr = (lat_addr == `MDS_EEDR_ADR);
  assign hit_earl = (lat_addr == `MDS_EEARL_ADR);
  assign hit_earh = (lat_addr == `MDS_EEARH_ADR);
  assign lat_ptr_val = ptr_of(lat_psel);

  // strobe bit reads the write timer, so software polls it
  assign rd_mux = hit_eecr ? {4'h0, ee_rdyie, ee_arm, ee_busy, 1'b0} :
                  hit_eedr ? ee_data :
                  hit_earl ? ee_addr[7:0] :
                  hit_earh ? {6'h00, ee_addr[9:8]} :
                  (rgn == MDS_RGN_REGF) ? rf[lat_addr[4:0]] :
                  ((rgn == MDS_RGN_IO) || (rgn == MDS_RGN_EXT)) ? io_mem[io_ofs[7:0]] :
                  (rgn == MDS_RGN_SRAM) ? sram[sram_ofs[10:0]] : 8'h00;

  // control register write effects
  assign ee_cr_wr   = in_acc && lat_we && hit_eecr;
  assign ee_arm_set = ee_cr_wr && lat_wd[`MDS_EECR_ARM];
  assign ee_arm_clr = ee_cr_wr && !lat_wd[`MDS_EECR_ARM];
  assign ee_wr_go   = ee_cr_wr && lat_wd[`MDS_EECR_STROBE] && ee_arm && !ee_busy;
  assign ee_rd_go   = ee_cr_wr && lat_wd[`MDS_EECR_READ] && !ee_busy && !ee_wr_go;
  assign ee_ar_wr   = in_acc && lat_we && (hit_earl || hit_earh) && !ee_busy;

  // stall count: four for read, two for write start
  assign next_stall_cnt = ee_rd_go ? `MDS_EE_RD_STALL :
                          ee_wr_go ? `MDS_EE_WR_STALL :
                          (stall_cnt != 3'h0) ? stall_cnt - 3'h1 : 3'h0;
  // arm window closes by itself after four cycles
  assign next_arm_cnt = ee_arm_set ? `MDS_ARM_WINDOW :
                        (arm_cnt != 3'h0) ? arm_cnt - 3'h1 : 3'h0;
  assign next_arm     = ee_arm_set ? 1'b1 :
                        (ee_arm_clr || (arm_cnt == 3'h1)) ? 1'b0 : ee_arm;

  ////////////////////////////////////////////////////////////
  // arrays are not reset; pointer write-back after data so it wins
  always_ff @(posedge ref_clk)
  begin
    if (in_acc && lat_we && (rgn == MDS_RGN_REGF))
      rf[lat_addr[4:0]] <= lat_wd;
    if (in_acc && lat_we && ((rgn == MDS_RGN_IO) || (rgn == MDS_RGN_EXT)))
      io_mem[io_ofs[7:0]] <= lat_wd;
    if (in_acc && lat_we && (rgn == MDS_RGN_SRAM))
      sram[sram_ofs[10:0]] <= lat_wd;
    if (in_acc && lat_wb)
    begin
      rf[5'd26 + {2'b00, lat_psel, 1'b0}] <= lat_pnew[7:0];
      rf[5'd27 + {2'b00, lat_psel, 1'b0}] <= lat_pnew[15:8];
    end
  end

  // eeprom registers and cpu-side answers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ee_addr        <= 10'h000;
      ee_data        <= 8'h00;
      ee_arm         <= 1'b0;
      ee_rdyie       <= 1'b0;
      arm_cnt        <= 3'h0;
      stall_cnt      <= 3'h0;
      acc_ack        <= 1'b0;
      acc_rdata      <= 8'h00;
      acc_fault      <= 1'b0;
      cpu_stall      <= 1'b0;
      powerdown_full <= 1'b0;
    end
    else
    begin
      if (ee_ar_wr && hit_earl)
        ee_addr[7:0] <= lat_wd;
      if (ee_ar_wr && hit_earh)
        ee_addr[9:8] <= lat_wd[1:0];
      if (ee_rd_go)
        ee_data <= ee_rd_byte;
      else if (in_acc && lat_we && hit_eedr)
        ee_data <= lat_wd;
      if (ee_cr_wr)
        ee_rdyie <= lat_wd[`MDS_EECR_RDYIE];
      ee_arm         <= next_arm;
      arm_cnt        <= next_arm_cnt;
      stall_cnt      <= next_stall_cnt;
      cpu_stall      <= (next_stall_cnt != 3'h0);
      acc_ack        <= in_acc;
      acc_rdata      <= in_acc ? rd_mux : acc_rdata;
      acc_fault      <= in_acc && (rgn == MDS_RGN_NONE);
      // full power-down only once the write timer is idle
      powerdown_full <= powerdown_req && !ee_busy;
    end
  end

  ////////////////////////////////////////////////////////////
  // busy doubles as the oscillator hold during power-down
  mds_eeprom #(
    .RC_CYCLES (EE_WRITE_RC_CYCLES)
  ) u_eeprom (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .rc_tick (rc_tick),
    .wr_go   (ee_wr_go),
    .addr    (ee_addr),
    .wr_data (ee_data),
    .busy    (ee_busy),
    .rd_byte (ee_rd_byte)
  );
  assign rc_osc_hold = ee_busy;

  mds_flash u_flash (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .pc          (fetch_pc),
    .instr       (fetch_instr),
    .in_boot     (fetch_in_boot),
    .spm_req     (spm_req),
    .spm_addr    (spm_addr),
    .spm_data    (spm_data),
    .boot_lock   (boot_lock),
    .app_lock    (app_lock),
    .spm_refused (spm_refused)
  );

  ////////////////////////////////////////////////////////////
  // checks on timing and eeprom sequencing
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_sram_two_cycle: assert property (take |=> !acc_ack ##1 acc_ack)
    else $error("access not answered two cycles after take");
  a_read_stall_four: assert property (ee_rd_go |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("eeprom read stall is not four cycles");
  a_write_stall_two: assert property (ee_wr_go |=> cpu_stall[*2] ##1 !cpu_stall)
    else $error("eeprom write stall is not two cycles");
  a_arm_window_four: assert property (ee_arm_set ##1 (!ee_arm_set && !ee_arm_clr)[*4] |-> ee_arm ##1 !ee_arm)
    else $error("arm bit did not clear four cycles after set");
  a_strobe_needs_arm: assert property ($rose(ee_busy) |-> $past(ee_arm) && $past(ee_cr_wr))
    else $error("eeprom write started without arming");
  a_addr_frozen_busy: assert property (ee_busy |=> $stable(ee_addr))
    else $error("eeprom address changed during write");
  a_read_blocked_busy: assert property (ee_cr_wr && lat_wd[`MDS_EECR_READ] && ee_busy
                                        |=> !cpu_stall && $stable(ee_data))
    else $error("eeprom read honoured during write");
  a_postinc_write_back: assert property (take && (mode == MDS_POSTINC) && !acc_short_io
                                         |-> ##2 (lat_ptr_val == $past(ptr_val, 2) + 16'h0001))
    else $error("post-increment pointer not written back");
  a_short_io_range: assert property (take && acc_short_io
                                     |=> (lat_addr >= `MDS_IO_BASE) && (lat_addr < `MDS_IO_END))
    else $error("short io access left the standard io range");

  c_eeprom_read: cover property (ee_rd_go ##1 cpu_stall[*4]);
  c_eeprom_write: cover property (ee_arm_set ##[1:4] ee_wr_go);
  c_sram_access: cover property (take && (mds_region(ea) == MDS_RGN_SRAM) ##2 acc_ack);
endmodule
`default_nettype wire

// file: src/mds_pkg.sv
// types and decode function shared by the memory subsystem
`default_nettype none
`include "mds_defs.svh"
package mds_pkg;
  typedef enum logic [2:0] {MDS_DIRECT, MDS_DISP, MDS_IND, MDS_PREDEC, MDS_POSTINC} mds_mode_t;
  typedef enum logic [1:0] {MDS_PX, MDS_PY, MDS_PZ} mds_ptr_t;
  typedef enum logic [2:0] {MDS_RGN_REGF, MDS_RGN_IO, MDS_RGN_EXT, MDS_RGN_SRAM, MDS_RGN_NONE} mds_region_t;
  typedef enum logic {MDS_IDLE, MDS_ACCESS} mds_state_t;

  // linear data space split into its four regions
  function automatic mds_region_t mds_region(input logic [15:0] a);
    mds_region_t r;
    r = MDS_RGN_NONE;
    if (a < `MDS_REGF_END)
      r = MDS_RGN_REGF;
    else if (a < `MDS_IO_END)
      r = MDS_RGN_IO;
    else if (a < `MDS_EXT_END)
      r = MDS_RGN_EXT;
    else if (a < `MDS_SRAM_END)
      r = MDS_RGN_SRAM;
    return r;
  endfunction
endpackage
`default_nettype wire

// file: test/mds_cpu_model.sv
// cpu core model issuing load and store requests
`timescale 1ns/100ps
`default_nettype none
module mds_cpu_model (
  input  wire logic        ref_clk,
  input  wire logic        acc_ack,
  input  wire logic [7:0]  acc_rdata,
  input  wire logic        acc_fault,
  input  wire logic        cpu_stall,
  output logic             acc_req,
  output logic             acc_write,
  output logic             acc_short_io,
  output logic [2:0]       acc_mode,
  output logic [1:0]       acc_ptr,
  output logic [15:0]      acc_addr,
  output logic [5:0]       acc_disp,
  output logic [7:0]       acc_wdata
);
  ////////////////////////////////////////////////////////////
  // quiet bus at time zero
  initial
  begin
    acc_req      = 1'b0;
    acc_write    = 1'b0;
    acc_short_io = 1'b0;
    acc_mode     = 3'h0;
    acc_ptr      = 2'h0;
    acc_addr     = 16'h0000;
    acc_disp     = 6'h00;
    acc_wdata    = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // one access after gap idle cycles; the request stands for the take edge only,
  // since one held three cycles or more would be taken twice; qualifiers hold until the ack edge
  task automatic access(input logic wr, input logic sio, input logic [2:0] md, input logic [1:0] pt,
                        input logic [15:0] ad, input logic [5:0] ds, input logic [7:0] wd, input int gap,
                        output logic [7:0] rd, output logic flt, output int lat, output int stl);
    repeat (gap + 1) @(posedge ref_clk);
    acc_req      <= 1'b1;
    acc_write    <= wr;
    acc_short_io <= sio;
    acc_mode     <= md;
    acc_ptr      <= pt;
    acc_addr     <= ad;
    acc_disp     <= ds;
    acc_wdata    <= wd;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    lat = 0;
    do
    begin
      @(posedge ref_clk);
      lat++;
    end
    while (acc_ack !== 1'b1 && lat < 9);
    rd  = acc_rdata;
    flt = acc_fault;
    // released address, data and displacement lines show the inverse, never the stale value
    acc_addr  <= ~ad;
    acc_wdata <= ~wd;
    acc_disp  <= ~ds;
    // no new request while the core is halted
    stl = 0;
    while (cpu_stall === 1'b1 && stl < 20)
    begin
      stl++;
      @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench of the memory subsystem against a behavioural model
`timescale 1ns/100ps
`default_nettype none
`include "mds_defs.svh"
module tb;
  localparam int RC = 8;  // short write time keeps the run small
  logic        ref_clk, rst_b, acc_req, acc_write, acc_short_io, acc_ack, acc_fault, cpu_stall;
  logic        fetch_in_boot, spm_req, boot_lock, app_lock, spm_refused, rc_tick, powerdown_req;
  logic        rc_osc_hold, powerdown_full, flt;
  logic [15:0] acc_addr, fetch_instr, spm_data;
  logic [13:0] fetch_pc, spm_addr;
  logic [7:0]  acc_wdata, acc_rdata, rd;
  logic [5:0]  acc_disp;
  logic [2:0]  acc_mode;
  logic [1:0]  acc_ptr;
  logic [31:0] seed;
  int          lat, stl, ticks, errors, cmp_count;
  int          mem [0:2303];
  int          ee [0:1023];
  int          fl [int];

  mds_memsys #(.EE_WRITE_RC_CYCLES(RC)) u_mds_memsys (.*);
  mds_cpu_model u_cpu (.*);

  ////////////////////////////////////////////////////////////
  // clock, random oscillator ticks and the count of ticks while a write is held
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    rc_tick <= (rnd() & 32'h3) == 32'h0;
    if (rc_osc_hold === 1'b1 && rc_tick === 1'b1)
      ticks <= ticks + 1;
  end
  // hang guard, about twice the expected run
  initial
  begin
    #200000;
    errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // one access; the model forms the address and keeps the data space
  task automatic op(input int wr, input int sio, input int md, input int pt, input int ad, input int ds,
                    input int wd, input int gap);
    int a;
    int p;
    int f;
    p = 26 + 2 * pt;
    a = ad & 32'hFFFF;
    if (sio != 0)
      a = (ad & 32'h3F) + 32'h20;
    else if (md != 0)
      a = mem[p] + 256 * mem[p + 1] + ((md == 1 && pt != 0) ? ds : 0) - (md == 3);
    if (sio == 0 && md >= 3)
    begin
      mem[p] = (md == 3 ? a : a + 1) % 256;
      mem[p + 1] = (md == 3 ? a : a + 1) / 256;
    end
    f = a >= 32'h900;
    u_cpu.access(wr[0], sio[0], md[2:0], pt[1:0], ad[15:0], ds[5:0], wd[7:0], gap, rd, flt, lat, stl);
    check("ack latency", lat, 2);
    check("fault", flt, f);
    if (wr != 0 && f == 0)
      mem[a] = (a >= 32'h3F && a <= 32'h42) ? -1 : wd & 32'hFF;
    if (wr == 0 && (f != 0 || mem[a] >= 0))
      check("load data", rd, f ? 0 : mem[a]);
    if (a != 32'h3F)
      check("stall", stl, 0);
  endtask
  task automatic ee_setup(input int ea, input int d);
    op(1, 0, 0, 0, `MDS_EEARL_ADR, 0, ea & 32'hFF, 0);
    op(1, 0, 0, 0, `MDS_EEARH_ADR, 0, ea >> 8, 0);
    op(1, 0, 0, 0, `MDS_EEDR_ADR, 0, d, 0);
  endtask
  // arm, then strobe after gap idle cycles; only gap 0 lands inside the arm window
  task automatic ee_write(input int ea, input int d, input int gap);
    ee_setup(ea, d);
    op(1, 0, 0, 0, `MDS_EECR_ADR, 0, 8'h04, 0);
    ticks = 0;
    op(1, 0, 0, 0, `MDS_EECR_ADR, 0, 8'h02, gap);
    if (gap < 1)
      ee[ea] = d & 32'hFF;
    check("write stall", stl, gap < 1 ? 2 : 0);
    check("write busy", rc_osc_hold, gap < 1);
  endtask
  task automatic ee_wait(output int n);
    n = 0;
    do
    begin
      op(0, 0, 0, 0, `MDS_EECR_ADR, 0, 0, 0);
      n++;
    end
    while (rd[1] === 1'b1 && n < 100);
    check("write ends", n < 100, 1);
  endtask
  task automatic ee_read(input int ea);
    ee_setup(ea, 0);
    op(1, 0, 0, 0, `MDS_EECR_ADR, 0, 8'h01, 0);
    check("read stall", stl, 4);
    op(0, 0, 0, 0, `MDS_EEDR_ADR, 0, 0, 0);
    check("eeprom byte", rd, ee[ea]);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    int v;
    int ea;
    int fa;
    int lk;
    seed = 32'h0001621B;
    rst_b = 1'b0;
    fetch_pc = 14'h0000;
    spm_req = 1'b0;
    spm_addr = 14'h0000;
    spm_data = 16'h0000;
    boot_lock = 1'b0;
    app_lock = 1'b0;
    rc_tick = 1'b0;
    powerdown_req = 1'b0;
    ticks = 0;
    errors = 0;
    cmp_count = 0;
    foreach (mem[i]) mem[i] = -1;
    foreach (ee[i]) ee[i] = -1;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    // data space except the eeprom registers written then read back directly; past the end faults
    for (int a = 0; a < 32'h901; a++)
      if (a < 32'h3F || a > 32'h42)
        op(1, 0, 0, 0, a, 0, rnd(), 0);
    for (int a = 0; a < 32'h901; a++)
      if (a < 32'h3F || a > 32'h42)
        op(0, 0, 0, 0, a, 0, 0, 0);
    // short io folds onto 0x20..0x5F and never reaches extended io
    for (int i = 0; i < 24; i++)
    begin
      v = rnd() & 32'h3F;
      if (v < 32'h1F || v > 32'h22)
        op(1, 1, 0, 0, (rnd() & 32'hFFC0) | v, 0, rnd(), 0);
      op(0, 1, 0, 0, v, 0, 0, 0);
    end
    for (int a = 32'h60; a < 32'h100; a++)
      op(0, 0, 0, 0, a, 0, 0, 0);
    // random modes through freshly loaded pointers, random spacing
    for (int i = 0; i < 300; i++)
    begin
      n = rnd() % 3;
      v = 32'h200 + rnd() % 32'h600;
      op(1, 0, 0, 0, 26 + 2 * n, 0, v % 256, 0);
      op(1, 0, 0, 0, 27 + 2 * n, 0, v / 256, 0);
      op(rnd() % 2, 0, rnd() % 5, n, v, rnd() % 64, rnd(), rnd() % 3);
      op(0, 0, 0, 0, 26 + 2 * n, 0, 0, 0);
    end
    // eeprom: edges of the space, blocked read and address while busy, late strobe
    for (int i = 0; i < 3; i++)
    begin
      ea = i == 0 ? 0 : (i == 1 ? 1023 : rnd() % 1024);
      v = rnd() & 32'hFF;
      ee_write(ea, v, 0);
      op(1, 0, 0, 0, `MDS_EEARL_ADR, 0, ea + 1, 0);
      op(1, 0, 0, 0, `MDS_EECR_ADR, 0, 8'h01, 0);
      ee_wait(n);
      check("busy seen", n > 1, 1);
      check("write time", ticks, RC);
      op(0, 0, 0, 0, `MDS_EEARL_ADR, 0, 0, 0);
      check("frozen address", rd, ea & 32'hFF);
      op(0, 0, 0, 0, `MDS_EEDR_ADR, 0, 0, 0);
      check("data after blocked read", rd, v);
      ee_write(ea, v ^ 32'hFF, 1);
      ee_read(ea);
    end
    // reset in mid-write must not abort it
    ee_write(5, 8'h3C, 0);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("write held in reset", rc_osc_hold, 1);
    rst_b <= 1'b1;
    ee_wait(n);
    ee_read(5);
    // power-down during a write waits for it
    powerdown_req <= 1'b1;
    ee_write(9, 8'hA5, 0);
    repeat (2) @(posedge ref_clk);
    check("partial power-down", powerdown_full, 0);
    ee_wait(n);
    repeat (2) @(posedge ref_clk);
    check("full power-down", powerdown_full, 1);
    powerdown_req <= 1'b0;
    ee_read(9);
    // flash: each lock pairing against one word either side of the boot edge
    for (int k = 0; k < 8; k++)
    begin
      fa = k[0] ? `MDS_BOOT_START + k - 1 : `MDS_BOOT_START - 1 - k;
      lk = k[0] ? k[2] : k[1];
      v = rnd() & 32'hFFFF;
      @(posedge ref_clk);
      app_lock <= k[1];
      boot_lock <= k[2];
      spm_req <= 1'b1;
      spm_addr <= fa[13:0];
      spm_data <= v[15:0];
      @(posedge ref_clk);
      spm_req <= 1'b0;
      fetch_pc <= fa[13:0];
      @(posedge ref_clk);
      check("flash lock", spm_refused, lk);
      if (lk == 0)
        fl[fa] = v;
      repeat (2) @(posedge ref_clk);
      if (fl.exists(fa))
        check("flash word", fetch_instr, fl[fa]);
      check("boot section", fetch_in_boot, fa >= `MDS_BOOT_START);
    end
    conclude();
  end
endmodule
`default_nettype wire
